// ==== rtl/can_cfg_defines.svh ====
`ifndef CAN_CFG_DEFINES_SVH
`define CAN_CFG_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_TIMING_PRESCALE  8'hB4
`define ADDR_TIMING_JUMP_PROP 8'hB5
`define ADDR_STATUS_HIGH      8'hBA
`define ADDR_STATUS_LOW       8'hBB
`define ADDR_IRQ_EN_HIGH      8'hC2
`define ADDR_IRQ_EN_LOW       8'hC3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PRESCALE_MSB 6
`define PRESCALE_LSB 1
`define JUMP_MSB     6
`define JUMP_LSB     5
`define PROP_MSB     3
`define PROP_LSB     1
`define HIGH_MSB     6
`define CHAN_SPLIT   8

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define IRQ_EN_HIGH_RST 7'h00
`define IRQ_EN_LOW_RST  8'h00
`define STATUS_RST      15'h0000
`define RDATA_IDLE      8'h00
`define NUM_CHAN        15

`endif

// ==== rtl/can_cfg_pkg.sv ====
package can_cfg_pkg;

	typedef enum logic [3:0] {
		ST_SYNC = 4'h1,
		ST_PROP = 4'h2,
		ST_PH1  = 4'h4,
		ST_PH2  = 4'h8
	} seg_state_t;

	typedef logic [14:0] chan_vec_t;

endpackage

// ==== rtl/can_cfg_if.sv ====
`timescale 1ns/1ps

interface can_cfg_if;
	logic                  wr;
	logic                  rd;
	logic [7:0]            addr;
	logic [7:0]            wdata;
	logic [7:0]            rdata;
	can_cfg_pkg::chan_vec_t chan_evt;
	logic                  irq;
	logic [5:0]            prescale;
	logic [1:0]            sjw;
	logic [2:0]            prop;

	modport regs (
		input  wr,
		input  rd,
		input  addr,
		input  wdata,
		input  chan_evt,
		output rdata,
		output irq,
		output prescale,
		output sjw,
		output prop
	);

	modport core (
		output wr,
		output rd,
		output addr,
		output wdata,
		output chan_evt,
		input  rdata,
		input  irq,
		input  prescale,
		input  sjw,
		input  prop
	);
endinterface

// ==== rtl/can_cfg_regs.sv ====
`timescale 1ns/1ps
`include "can_cfg_defines.svh"

module can_cfg_regs (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	can_cfg_if.regs  bus
);

	logic [6:0]  en_high_q;
	logic [7:0]  en_low_q;
	logic [14:0] stat_q;
	logic [14:0] stat_d;
	logic [5:0]  prescale_q;
	logic [1:0]  sjw_q;
	logic [2:0]  prop_q;
	logic [7:0]  rdata_q;
	logic        irq_q;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire        wr_psc   = bus.wr && bus.addr == `ADDR_TIMING_PRESCALE;
	wire        wr_jmp   = bus.wr && bus.addr == `ADDR_TIMING_JUMP_PROP;
	wire        wr_sth   = bus.wr && bus.addr == `ADDR_STATUS_HIGH;
	wire        wr_stl   = bus.wr && bus.addr == `ADDR_STATUS_LOW;
	wire        wr_enh   = bus.wr && bus.addr == `ADDR_IRQ_EN_HIGH;
	wire        wr_enl   = bus.wr && bus.addr == `ADDR_IRQ_EN_LOW;
	wire [14:0] en_all   = {en_high_q, en_low_q};
	wire [14:0] stat_clr = {wr_sth ? bus.wdata[`HIGH_MSB:0] : 7'h00,
		wr_stl ? bus.wdata : 8'h00};
	wire        irq_d    = |(stat_d & en_all);

	wire [7:0] rd_val =
		(bus.addr == `ADDR_TIMING_PRESCALE)  ? {1'b0, prescale_q, 1'b0} :
		(bus.addr == `ADDR_TIMING_JUMP_PROP) ?
			{1'b0, sjw_q, 1'b0, prop_q, 1'b0} :
		(bus.addr == `ADDR_STATUS_HIGH)      ? {1'b0, stat_q[14:8]} :
		(bus.addr == `ADDR_STATUS_LOW)       ? stat_q[7:0] :
		(bus.addr == `ADDR_IRQ_EN_HIGH)      ? {1'b0, en_high_q} :
		(bus.addr == `ADDR_IRQ_EN_LOW)       ? en_low_q :
		`RDATA_IDLE;

	// sticky status
	// New event wins over a write-one clear in the same cycle
	assign stat_d = (stat_q & ~stat_clr) | bus.chan_evt;

	// ----------------------------------------------------------------
	// Resettable registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			en_high_q <= `IRQ_EN_HIGH_RST;
			en_low_q  <= `IRQ_EN_LOW_RST;
			stat_q    <= `STATUS_RST;
			rdata_q   <= `RDATA_IDLE;
			irq_q     <= 1'b0;
		end else if (i_clk_en) begin
			if (wr_enh)
				en_high_q <= bus.wdata[`HIGH_MSB:0];
			if (wr_enl)
				en_low_q <= bus.wdata;
			stat_q  <= stat_d;
			rdata_q <= bus.rd ? rd_val : `RDATA_IDLE;
			irq_q   <= irq_d;
		end
	end

	// ----------------------------------------------------------------
	// Timing registers, left unreset
	// ----------------------------------------------------------------
	// no reset value
	always_ff @(posedge i_ref_clk) begin
		if (i_clk_en && wr_psc)
			prescale_q <= bus.wdata[`PRESCALE_MSB:`PRESCALE_LSB];
		if (i_clk_en && wr_jmp) begin
			sjw_q  <= bus.wdata[`JUMP_MSB:`JUMP_LSB];
			prop_q <= bus.wdata[`PROP_MSB:`PROP_LSB];
		end
	end

	assign bus.rdata    = rdata_q;
	assign bus.irq      = irq_q;
	assign bus.prescale = prescale_q;
	assign bus.sjw      = sjw_q;
	assign bus.prop     = prop_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	irq_level_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_clk_en |=> bus.irq == $past(|(stat_d & en_all)))
		else $error("interrupt output disagrees with status and mask");

	set_wins_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_clk_en |=> ($past(bus.chan_evt) & ~stat_q) == 15'h0000)
		else $error("channel event lost");

	status_sticky_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_clk_en && !wr_sth && !wr_stl |=>
			(stat_q & $past(stat_q)) == $past(stat_q))
		else $error("status bit dropped without a clear");

	en_high_wr_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_clk_en && wr_enh |=>
			bus.rdata == 8'h00 && en_high_q == $past(bus.wdata[6:0]))
		else $error("upper enable write not stored");

	en_high_rsv_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_clk_en && bus.rd && bus.addr == `ADDR_IRQ_EN_HIGH |=>
			bus.rdata[7] == 1'b0 && bus.rdata[6:0] == en_high_q)
		else $error("upper enable read wrong");

	en_low_rd_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_clk_en && bus.rd && bus.addr == `ADDR_IRQ_EN_LOW |=>
			bus.rdata == $past(en_low_q))
		else $error("lower enable read wrong");

endmodule

// ==== rtl/can_cfg_top.sv ====
`timescale 1ns/1ps
`include "can_cfg_defines.svh"

//Contract
// - upper enables, channels 14-8, reset zero
// - lower enables, channels 7-0, reset zero
// - upper enable bit 7 reserved
// - prescaler field sets quantum period
// - timing reserved bits kept zero
// - timing registers have no reset value
// - resynchronize on every recessive-to-dominant edge; an edge still pending on the tick that ends the sync quantum or phase one is dropped
// - jump width limits correction, field plus one
// - propagation segment lasts field plus one
// - status sticky, interrupt needs its enable
module can_cfg_top (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_clk_en,
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [14:0] i_chan_event,
	input  wire logic        i_global_enable,
	input  wire logic [2:0]  i_phase1_seg,
	input  wire logic [2:0]  i_phase2_seg,
	input  wire logic        i_can_rx,
	output logic      [7:0]  o_rdata,
	output logic             o_irq,
	output logic             o_quantum_tick,
	output logic             o_bit_start,
	output logic             o_sample_point,
	output logic             o_sampled_bit
);

	can_cfg_if u_if ();

	can_cfg_pkg::seg_state_t state_q;
	can_cfg_pkg::seg_state_t state_d;
	logic [5:0] cnt_q;
	logic       tick_q;
	logic [3:0] seg_q;
	logic [3:0] seg_d;
	logic [4:0] pos_q;
	logic [4:0] pos_d;
	logic [2:0] ext_q;
	logic [2:0] ext_d;
	logic       pend_q;
	logic       rx_meta_q;
	logic       rx_sync_q;
	logic       rx_prev_q;
	logic       start_q;
	logic       start_d;
	logic       sample_q;
	logic       sample_d;
	logic       bit_q;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	assign u_if.wr       = i_wr;
	assign u_if.rd       = i_rd;
	assign u_if.addr     = i_addr;
	assign u_if.wdata    = i_wdata;
	assign u_if.chan_evt = i_chan_event;

	can_cfg_regs u_regs (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_clk_en  (i_clk_en),
		.bus       (u_if.regs)
	);

	// ----------------------------------------------------------------
	// Derived timing terms
	// ----------------------------------------------------------------
	// fields assumed stable while enabled
	wire       en       = i_global_enable;
	wire [2:0] jump_len = {1'b0, u_if.sjw} + 3'h1;
	wire       rx_fall  = rx_prev_q & ~rx_sync_q;
	wire [4:0] pos_err  = pos_q + 5'h01;
	wire [2:0] ext_new  = (pos_err < {2'b00, jump_len}) ?
		pos_err[2:0] : jump_len;
	wire [3:0] ph1_end  = {1'b0, i_phase1_seg} + {1'b0, ext_q};
	wire [3:0] ph2_left = {1'b0, i_phase2_seg} - seg_q;
	wire       ph2_cut  = ph2_left < {1'b0, jump_len};
	wire       ph2_fit  = ph2_left == {1'b0, jump_len};
	// propagation ends after field plus one
	wire       seg_end  =
		(state_q == can_cfg_pkg::ST_SYNC) ? 1'b1 :
		(state_q == can_cfg_pkg::ST_PROP) ? seg_q == {1'b0, u_if.prop} :
		(state_q == can_cfg_pkg::ST_PH1)  ? seg_q == ph1_end :
		seg_q == {1'b0, i_phase2_seg};

	// ----------------------------------------------------------------
	// Bit segment sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d  = state_q;
		seg_d    = seg_q;
		pos_d    = pos_q;
		ext_d    = ext_q;
		start_d  = 1'b0;
		sample_d = 1'b0;
		if (!en) begin
			state_d = can_cfg_pkg::ST_SYNC;
			seg_d   = 4'h0;
			pos_d   = 5'h00;
			ext_d   = 3'h0;
		end else if (tick_q) begin
			case (state_q)
				can_cfg_pkg::ST_SYNC: begin
					state_d = can_cfg_pkg::ST_PROP;
					seg_d   = 4'h0;
					pos_d   = 5'h00;
					ext_d   = 3'h0;
					start_d = 1'b1;
				end
				can_cfg_pkg::ST_PROP,
				can_cfg_pkg::ST_PH1: begin
					pos_d = pos_q + 5'h01;
					if (pend_q)
						ext_d = ext_new;
					if (seg_end) begin
						seg_d    = 4'h0;
						state_d  = (state_q == can_cfg_pkg::ST_PROP) ?
							can_cfg_pkg::ST_PH1 : can_cfg_pkg::ST_PH2;
						sample_d = state_q == can_cfg_pkg::ST_PH1;
					end else begin
						seg_d = seg_q + 4'h1;
					end
				end
				can_cfg_pkg::ST_PH2: begin
					if (pend_q && ph2_cut) begin
						state_d = can_cfg_pkg::ST_PROP;
						seg_d   = 4'h0;
						pos_d   = 5'h00;
						ext_d   = 3'h0;
						start_d = 1'b1;
					end else if (seg_end || (pend_q && ph2_fit)) begin
						// exact jump lands on the sync quantum
						state_d = can_cfg_pkg::ST_SYNC;
						seg_d   = 4'h0;
					end else begin
						// skip jump quanta on an early edge
						seg_d = seg_q + 4'h1 +
							(pend_q ? {1'b0, jump_len} : 4'h0);
					end
				end
				default: begin
					state_d = can_cfg_pkg::ST_SYNC;
					seg_d   = 4'h0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Receive synchroniser and quantum prescaler
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
			rx_prev_q <= 1'b1;
			pend_q    <= 1'b0;
			cnt_q     <= 6'h00;
			tick_q    <= 1'b0;
		end else if (i_clk_en) begin
			rx_meta_q <= i_can_rx;
			rx_sync_q <= rx_meta_q;
			rx_prev_q <= rx_sync_q;
			// Edge held until the next quantum boundary
			pend_q    <= en & (rx_fall | (pend_q & ~tick_q));
			if (!en) begin
				cnt_q  <= 6'h00;
				tick_q <= 1'b0;
			end else if (cnt_q == 6'h00) begin
				cnt_q  <= u_if.prescale;
				tick_q <= 1'b1;
			end else begin
				cnt_q  <= cnt_q - 6'h01;
				tick_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q  <= can_cfg_pkg::ST_SYNC;
			seg_q    <= 4'h0;
			pos_q    <= 5'h00;
			ext_q    <= 3'h0;
			start_q  <= 1'b0;
			sample_q <= 1'b0;
			bit_q    <= 1'b1;
		end else if (i_clk_en) begin
			state_q  <= state_d;
			seg_q    <= seg_d;
			pos_q    <= pos_d;
			ext_q    <= ext_d;
			start_q  <= start_d;
			sample_q <= sample_d;
			if (sample_d)
				bit_q <= rx_sync_q;
		end
	end

	assign o_rdata        = u_if.rdata;
	assign o_irq          = u_if.irq;
	assign o_quantum_tick = tick_q;
	assign o_bit_start    = start_q;
	assign o_sample_point = sample_q;
	assign o_sampled_bit  = bit_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [5:0] gap_q;
	logic       seen_q;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gap_q  <= 6'h00;
			seen_q <= 1'b0;
		end else if (i_clk_en) begin
			gap_q  <= tick_q ? 6'h00 : gap_q + 6'h01;
			seen_q <= en & (seen_q | tick_q);
		end
	end

	tq_period_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_clk_en && en && tick_q && seen_q |-> gap_q == u_if.prescale)
		else $error("quantum period differs from prescale plus one");

	prop_len_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_clk_en && en && tick_q && state_q == can_cfg_pkg::ST_PROP &&
			seg_q == {1'b0, u_if.prop} |=>
			state_q == can_cfg_pkg::ST_PH1 && seg_q == 4'h0)
		else $error("propagation segment length wrong");

	jump_limit_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		state_q == can_cfg_pkg::ST_PH1 |-> ext_q <= jump_len)
		else $error("resync extension beyond jump width");

	resync_cut_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_clk_en && en && tick_q && pend_q && ph2_cut &&
			state_q == can_cfg_pkg::ST_PH2 |=>
			state_q == can_cfg_pkg::ST_PROP && start_q)
		else $error("early edge did not start a new bit");

	sample_pulse_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_clk_en && sample_q |-> $past(state_q) == can_cfg_pkg::ST_PH1 &&
			state_q == can_cfg_pkg::ST_PH2)
		else $error("sample point outside phase one end");

endmodule

// ==== bench/can_node_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Remote node: holds the bus dominant for a chosen number of cycles
// ----------------------------------------------------------------
module can_node_model (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_go,
	input  wire logic [7:0] i_len,
	output logic            o_rx
);
	logic [7:0] cnt_q;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 8'h00;
		end else if (i_go) begin
			cnt_q <= i_len;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end

	// Released bus is pulled recessive by the termination
	assign o_rx = (cnt_q == 8'h00);
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
	logic        i_ref_clk;
	logic        i_rst_n;
	logic        i_wr;
	logic        i_rd;
	logic [7:0]  i_addr;
	logic [7:0]  i_wdata;
	logic [14:0] i_chan_event;
	logic        i_global_enable;
	logic [2:0]  ph1;
	logic [2:0]  ph2;
	logic        rx;
	logic        rx_go;
	logic        clk_en;
	logic [7:0]  o_rdata;
	logic        o_irq;
	logic        o_quantum_tick;
	logic        o_bit_start;
	logic        o_sample_point;
	logic        o_sampled_bit;
	int          err_count;
	int          check_count;
	int          st;
	int          en;
	int          v;
	int          n;
	int          a;
	int          b;
	int          pr;
	int          pv[3] = '{0, 17, 63};

	can_cfg_top dut (
		.i_ref_clk       (i_ref_clk),
		.i_rst_n         (i_rst_n),
		.i_clk_en        (clk_en),
		.i_addr          (i_addr),
		.i_wdata         (i_wdata),
		.i_wr            (i_wr),
		.i_rd            (i_rd),
		.i_chan_event    (i_chan_event),
		.i_global_enable (i_global_enable),
		.i_phase1_seg    (ph1),
		.i_phase2_seg    (ph2),
		.i_can_rx        (rx),
		.o_rdata         (o_rdata),
		.o_irq           (o_irq),
		.o_quantum_tick  (o_quantum_tick),
		.o_bit_start     (o_bit_start),
		.o_sample_point  (o_sample_point),
		.o_sampled_bit   (o_sampled_bit)
	);

	can_node_model node (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_go      (rx_go),
		.i_len     (8'h3C),
		.o_rx      (rx)
	);

	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= ad;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask

	task rdchk(input string nm, input logic [7:0] ad, input logic [7:0] e);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= ad;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(negedge i_ref_clk);
		chk(nm, {8'h00, e}, {8'h00, o_rdata});
	endtask

	// Disable, program timing and phases, read back, enable again
	task tcfg(input int p, input int pg, input int j, input int x, input int y);
		@(posedge i_ref_clk);
		i_global_enable <= 1'b0;
		ph1 <= x[2:0];
		ph2 <= y[2:0];
		wr(8'hB4, {1'b0, p[5:0], 1'b0});
		wr(8'hB5, {1'b0, j[1:0], 1'b0, pg[2:0], 1'b0});
		rdchk("timing_prescale", 8'hB4, {1'b0, p[5:0], 1'b0});
		rdchk("timing_jump_prop", 8'hB5, {1'b0, j[1:0], 1'b0, pg[2:0], 1'b0});
		@(posedge i_ref_clk);
		i_global_enable <= 1'b1;
	endtask

	// Cycles between two pulses; optional dominant kick after the first
	task gap(input int sel, input int kick, output int cnt);
		bit p;
		p = 1'b0;
		cnt = 0;
		for (int i = 0; i < 2000 && !p; i++) begin
			@(negedge i_ref_clk);
			p = sel ? (o_bit_start === 1'b1) : (o_quantum_tick === 1'b1);
		end
		p = 1'b0;
		while (!p && cnt < 2000) begin
			@(negedge i_ref_clk);
			cnt++;
			rx_go <= (cnt == kick);
			p = (sel == 2) ? (o_sample_point === 1'b1) :
				sel ? (o_bit_start === 1'b1) : (o_quantum_tick === 1'b1);
		end
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge i_ref_clk);
		err_count++;
		complete_run;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		i_rst_n = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		i_chan_event = 15'h0000;
		i_global_enable = 1'b0;
		ph1 = 3'h3;
		ph2 = 3'h3;
		rx_go = 1'b0;
		clk_en = 1'b1;
		err_count = 0;
		check_count = 0;
		st = 0;
		v = $urandom(34);
		repeat (20) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;

		rdchk("irq_en_high", 8'hC2, 8'h00);
		rdchk("irq_en_low", 8'hC3, 8'h00);
		rdchk("unmapped", 8'h10, 8'h00);
		repeat (4) begin
			en = $urandom & 32'h7FFF;
			wr(8'hC2, {1'b0, en[14:8]});
			wr(8'hC3, en[7:0]);
			rdchk("irq_en_high", 8'hC2, {1'b0, en[14:8]});
			rdchk("irq_en_low", 8'hC3, en[7:0]);
		end
		// Clock enable low: read data holds, strobes are ignored
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= 8'hC3;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		clk_en <= 1'b0;
		wr(8'hC3, ~en[7:0]);
		@(negedge i_ref_clk);
		chk("rdata_hold", {8'h00, en[7:0]}, {8'h00, o_rdata});
		@(posedge i_ref_clk);
		clk_en <= 1'b1;
		rdchk("irq_en_low", 8'hC3, en[7:0]);
		$display("test registers done");

		repeat (10) begin
			v = $urandom & 32'h7FFF;
			@(posedge i_ref_clk);
			i_chan_event <= v[14:0];
			@(posedge i_ref_clk);
			i_chan_event <= 15'h0000;
			st |= v;
			@(negedge i_ref_clk);
			chk("irq_set", 16'((st & en) != 0), {15'h0000, o_irq});
			rdchk("status_high", 8'hBA, {1'b0, st[14:8]});
			rdchk("status_low", 8'hBB, st[7:0]);
			v = $urandom & st;
			wr(8'hBA, {1'b0, v[14:8]});
			wr(8'hBB, v[7:0]);
			st &= ~v;
			@(negedge i_ref_clk);
			chk("irq_clear", 16'((st & en) != 0), {15'h0000, o_irq});
		end
		$display("test interrupts done");

		foreach (pv[i]) begin
			tcfg(pv[i], 2, 1, 3, 3);
			gap(0, -1, n);
			chk("quantum_period", 16'(pv[i] + 1), 16'(n));
		end
		$display("test quantum done");

		repeat (4) begin
			pr = $urandom_range(7);
			a = $urandom_range(7);
			b = $urandom_range(7);
			tcfg(1, pr, 0, a, b);
			gap(1, -1, n);
			chk("bit_period", 16'((4 + pr + a + b) * 2), 16'(n));
			gap(2, -1, n);
			chk("sample_point", 16'((2 + pr + a) * 2), 16'(n));
		end
		$display("test bit period done");

		for (int s = 0; s < 4; s++) begin
			tcfg(1, 7, s, 3, 3);
			gap(1, 2, n);
			chk("resync_len", 16'h0001, 16'(n >= 36 && n <= 34 + 2 * (s + 1)));
			chk("sampled_bit", 16'h0000, {15'h0000, o_sampled_bit});
			repeat (80) @(posedge i_ref_clk);
			// Edge in the second phase-two quantum cuts the bit short
			gap(1, 22, n);
			chk("resync_early", 16'(34 - 2 * (s < 2 ? s + 1 : 3)), 16'(n));
			repeat (80) @(posedge i_ref_clk);
		end
		$display("test resync done");
		complete_run;
	end
endmodule
